//--- design/fspc_pkg.sv
// constants, enums and codes shared by both ends of the flash command link
// assumes one 25 MHz clock shared by device end and host end
package fspc_pkg;
  // ==========================================================
  // link widths and block map
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int CODE_W = 8;
  localparam int NUM_BLK = 8;
  localparam int BLK_LSB = 16;
  localparam int BLK_W = 3;
  localparam int CNT_W = 8;
  // ==========================================================
  // default command codes, arbitrary values
  localparam logic [7:0] CMD_READ_ARRAY = 8'hf0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_SIG = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_BUFPROG_SETUP = 8'he8;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'hd1;
  localparam logic [7:0] CMD_BCR_SETUP = 8'h60;
  localparam logic [7:0] CMD_PSET_SETUP = 8'h61;
  localparam logic [7:0] CMD_PCLR_SETUP = 8'h62;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  // ==========================================================
  // status register bit positions
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_PEN = 3;
  localparam int SR_PSUSP = 2;
  localparam int SR_PROT_ERR = 1;
  // ==========================================================
  // burst configuration layout and reset value
  localparam int BCR_W = 16;
  localparam int BCR_BURST_CFG_BIT0 = 0;
  localparam int BCR_LEN_W = 3;
  localparam int BCR_TYPE_BIT = 3;
  localparam int BCR_XLAT_LSB = 4;
  localparam int BCR_XLAT_W = 4;
  localparam int BCR_YLAT_LSB = 8;
  localparam int BCR_YLAT_W = 2;
  localparam int BCR_ASYNC_BIT = 15;
  localparam logic [15:0] BCR_RST = 16'h8000;
  // ==========================================================
  // read words, values arbitrary
  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
  localparam logic [31:0] SIG_WORD = 32'h0000_5a5a;
  localparam logic [31:0] QUERY_WORD = 32'h0000_1234;
  localparam logic [7:0] PROT_RST = 8'hff;
  // ==========================================================
  // timing in cycles of the 25 MHz clock
  localparam logic [7:0] PROG_CYCLES = 8'h10;
  localparam logic [7:0] ERASE_CYCLES = 8'h40;
  localparam logic [7:0] PAUSE_CYCLES = 8'h04;
  localparam logic [7:0] MIN_ERASE_GAP_CYCLES = 8'h20;
  // ==========================================================
  // host wishbone register map
  localparam int WB_ADR_W = 8;
  localparam logic [7:0] H_CMD_OFF = 8'h00;
  localparam logic [7:0] H_ADDR_OFF = 8'h04;
  localparam logic [7:0] H_DATA_OFF = 8'h08;
  localparam logic [7:0] H_STAT_OFF = 8'h0c;
  localparam logic [7:0] H_RDATA_OFF = 8'h10;
  localparam int HC_WRITE_BIT = 0;
  localparam int HC_READ_BIT = 1;
  localparam int HS_BUSY = 0;
  localparam int HS_RVALID = 1;
  localparam int HS_REFUSED = 2;
  // ==========================================================
  // state encodings
  typedef enum logic [3:0] {
    RM_ARRAY = 4'b0001, RM_STATUS = 4'b0010,
    RM_SIG = 4'b0100, RM_QUERY = 4'b1000
  } fspc_rmode_t;
  typedef enum logic [5:0] {
    PD_NONE = 6'b000001, PD_PROG = 6'b000010, PD_ERASE = 6'b000100,
    PD_BCR = 6'b001000, PD_PSET = 6'b010000, PD_PCLR = 6'b100000
  } fspc_pend_t;
  typedef enum logic [2:0] {
    PE_IDLE = 3'b001, PE_RUN = 3'b010, PE_PAUSE = 3'b100
  } fspc_pe_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001, HS_WRITE = 3'b010, HS_READ = 3'b100
  } fspc_hst_t;
endpackage

//--- design/fspc_link_if.sv
// parallel command link between host end and flash device end
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface fspc_link_if;
  logic wr;
  logic rd;
  logic [23:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rvalid;
  modport dev (input wr, input rd, input addr, input wdata,
    output rdata, output rvalid);
  modport host (output wr, output rd, output addr, output wdata,
    input rdata, input rvalid);
endinterface

//--- design/fspc_dev.sv
// flash device end: command decode, suspend/resume, config, protection
// assumes one-cycle wr/rd strobes from the host end on i_clock
`timescale 1ns/1ns
module fspc_dev #(
  parameter logic [7:0] P_READ_ARRAY = fspc_pkg::CMD_READ_ARRAY,
  parameter logic [7:0] P_READ_STATUS = fspc_pkg::CMD_READ_STATUS,
  parameter logic [7:0] P_READ_SIG = fspc_pkg::CMD_READ_SIG,
  parameter logic [7:0] P_READ_QUERY = fspc_pkg::CMD_READ_QUERY,
  parameter logic [7:0] P_CLR_STATUS = fspc_pkg::CMD_CLR_STATUS,
  parameter logic [7:0] P_PROG_SETUP = fspc_pkg::CMD_PROG_SETUP,
  parameter logic [7:0] P_BUFPROG_SETUP = fspc_pkg::CMD_BUFPROG_SETUP,
  parameter logic [7:0] P_ERASE_SETUP = fspc_pkg::CMD_ERASE_SETUP,
  parameter logic [7:0] P_SUSPEND = fspc_pkg::CMD_SUSPEND,
  parameter logic [7:0] P_RESUME = fspc_pkg::CMD_RESUME,
  parameter logic [7:0] P_BCR_SETUP = fspc_pkg::CMD_BCR_SETUP,
  parameter logic [7:0] P_PSET_SETUP = fspc_pkg::CMD_PSET_SETUP,
  parameter logic [7:0] P_PCLR_SETUP = fspc_pkg::CMD_PCLR_SETUP,
  parameter logic [7:0] P_CONFIRM = fspc_pkg::CMD_CONFIRM
) (
  input wire logic i_clock,
  input wire logic i_rst,
  fspc_link_if.dev link,
  input wire logic i_wp_n,
  output logic [15:0] o_bcr,
  output logic [7:0] o_prot,
  output logic o_pe_active
);
  // ==========================================================
  // state
  fspc_pkg::fspc_pe_t pe_r;
  fspc_pkg::fspc_rmode_t rmode_r;
  fspc_pkg::fspc_rmode_t rmode_nxt;
  fspc_pkg::fspc_pend_t pend_r;
  fspc_pkg::fspc_pend_t pend_nxt;
  logic run_erase_r;
  logic esusp_r;
  logic psusp_r;
  logic [7:0] ecnt_r;
  logic [7:0] pcnt_r;
  logic [7:0] pause_r;
  logic err_erase_r;
  logic err_prog_r;
  logic err_prot_r;
  logic [7:0] code;
  logic [2:0] blk;
  logic blk_locked;
  logic [7:0] act_cnt;
  logic op_done;
  logic pause_done;
  logic suspended;
  logic nest_ok;
  logic [7:0] sr;
  logic start_prog;
  logic start_erase;
  logic bcr_we;
  logic pset;
  logic pclr;
  logic seq_abort;
  logic prot_fail;
  logic susp_go;
  logic resume_go;
  logic clr_go;
  logic rmode_we;

  // ==========================================================
  // decode helpers
  assign code = link.wdata[7:0];
  assign blk = link.addr[fspc_pkg::BLK_LSB +: fspc_pkg::BLK_W];
  assign blk_locked = o_prot[blk] & ~i_wp_n;
  assign act_cnt = run_erase_r ? ecnt_r : pcnt_r;
  // operation may finish during the pause; completion wins
  assign op_done = (pe_r != fspc_pkg::PE_IDLE) && (act_cnt == 8'h01);
  assign pause_done = (pe_r == fspc_pkg::PE_PAUSE) &&
    (pause_r == 8'h01) && !op_done;
  assign suspended = esusp_r | psusp_r;
  assign nest_ok = esusp_r & ~psusp_r;

  // status word
  always_comb begin
    sr = 8'h00;
    sr[fspc_pkg::SR_READY] = (pe_r == fspc_pkg::PE_IDLE);
    sr[fspc_pkg::SR_ESUSP] = esusp_r;
    sr[fspc_pkg::SR_ERASE_ERR] = err_erase_r;
    sr[fspc_pkg::SR_PROG_ERR] = err_prog_r;
    sr[fspc_pkg::SR_PSUSP] = psusp_r;
    sr[fspc_pkg::SR_PROT_ERR] = err_prot_r;
  end

  // ==========================================================
  // command interpreter
  always_comb begin
    start_prog = 1'b0;
    start_erase = 1'b0;
    bcr_we = 1'b0;
    pset = 1'b0;
    pclr = 1'b0;
    seq_abort = 1'b0;
    prot_fail = 1'b0;
    susp_go = 1'b0;
    resume_go = 1'b0;
    clr_go = 1'b0;
    rmode_we = 1'b0;
    rmode_nxt = rmode_r;
    pend_nxt = fspc_pkg::PD_NONE;
    if (link.wr) begin
      if (pe_r == fspc_pkg::PE_PAUSE) begin
        // nothing accepted until paused
      end else if (pe_r == fspc_pkg::PE_RUN) begin
        // only status read and suspend while running
        if (code == P_SUSPEND) begin
          susp_go = 1'b1;
        end else if (code == P_READ_STATUS) begin
          rmode_we = 1'b1;
          rmode_nxt = fspc_pkg::RM_STATUS;
        end
      end else if (pend_r != fspc_pkg::PD_NONE) begin
        // second cycle of a two-cycle command
        rmode_we = 1'b1;
        rmode_nxt = fspc_pkg::RM_STATUS;
        case (pend_r)
          fspc_pkg::PD_PROG: begin
            if (blk_locked) prot_fail = 1'b1;
            else start_prog = 1'b1;
          end
          fspc_pkg::PD_ERASE: begin
            if (code != P_CONFIRM) seq_abort = 1'b1;
            else if (blk_locked) prot_fail = 1'b1;
            else start_erase = 1'b1;
          end
          fspc_pkg::PD_BCR: begin
            if (code != P_CONFIRM) begin
              seq_abort = 1'b1;
            end else begin
              bcr_we = 1'b1;
              rmode_nxt = fspc_pkg::RM_ARRAY;
            end
          end
          fspc_pkg::PD_PSET: begin
            if (code != P_CONFIRM) seq_abort = 1'b1;
            else pset = 1'b1;
          end
          fspc_pkg::PD_PCLR: begin
            if (code != P_CONFIRM) seq_abort = 1'b1;
            else pclr = 1'b1;
          end
          default: begin
            seq_abort = 1'b0;
          end
        endcase
      end else begin
        // first cycle, controller idle or suspended
        case (code)
          P_READ_ARRAY: begin
            rmode_we = 1'b1;
            rmode_nxt = fspc_pkg::RM_ARRAY;
          end
          P_READ_STATUS: begin
            rmode_we = 1'b1;
            rmode_nxt = fspc_pkg::RM_STATUS;
          end
          P_READ_SIG: begin
            rmode_we = 1'b1;
            rmode_nxt = fspc_pkg::RM_SIG;
          end
          P_READ_QUERY: begin
            rmode_we = 1'b1;
            rmode_nxt = fspc_pkg::RM_QUERY;
          end
          P_CLR_STATUS: begin
            clr_go = !suspended;
          end
          P_RESUME: begin
            if (suspended) begin
              resume_go = 1'b1;
              rmode_we = 1'b1;
              rmode_nxt = fspc_pkg::RM_STATUS;
            end
          end
          P_PROG_SETUP, P_BUFPROG_SETUP: begin
            if (!suspended || nest_ok) begin
              pend_nxt = fspc_pkg::PD_PROG;
              rmode_we = 1'b1;
              rmode_nxt = fspc_pkg::RM_STATUS;
            end
          end
          P_ERASE_SETUP: begin
            if (!suspended) pend_nxt = fspc_pkg::PD_ERASE;
          end
          P_BCR_SETUP: begin
            if (!suspended) pend_nxt = fspc_pkg::PD_BCR;
          end
          P_PSET_SETUP: begin
            if (!suspended || nest_ok) pend_nxt = fspc_pkg::PD_PSET;
          end
          P_PCLR_SETUP: begin
            if (!suspended || nest_ok) pend_nxt = fspc_pkg::PD_PCLR;
          end
          default: begin
            // suspend while idle or suspended is dropped
            clr_go = 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // program/erase controller phase
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pe_r <= fspc_pkg::PE_IDLE;
      run_erase_r <= 1'b0;
    end else if (start_prog) begin
      pe_r <= fspc_pkg::PE_RUN;
      run_erase_r <= 1'b0;
    end else if (start_erase) begin
      pe_r <= fspc_pkg::PE_RUN;
      run_erase_r <= 1'b1;
    end else if (resume_go) begin
      pe_r <= fspc_pkg::PE_RUN;
      run_erase_r <= ~psusp_r;
    end else if (susp_go) begin
      pe_r <= fspc_pkg::PE_PAUSE;
    end else if (op_done || pause_done) begin
      pe_r <= fspc_pkg::PE_IDLE;
    end
  end

  // remaining work of each operation, kept across a suspend
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ecnt_r <= 8'h00;
      pcnt_r <= 8'h00;
    end else if (start_erase) begin
      ecnt_r <= fspc_pkg::ERASE_CYCLES;
    end else if (start_prog) begin
      pcnt_r <= fspc_pkg::PROG_CYCLES;
    end else if (pe_r != fspc_pkg::PE_IDLE) begin
      if (run_erase_r) ecnt_r <= ecnt_r - 8'h01;
      else pcnt_r <= pcnt_r - 8'h01;
    end
  end

  // pause latency after suspend
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) pause_r <= 8'h00;
    else if (susp_go) pause_r <= fspc_pkg::PAUSE_CYCLES;
    else if (pe_r == fspc_pkg::PE_PAUSE) pause_r <= pause_r - 8'h01;
  end

  // suspend flags
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      esusp_r <= 1'b0;
      psusp_r <= 1'b0;
    end else if (pause_done) begin
      if (run_erase_r) esusp_r <= 1'b1;
      else psusp_r <= 1'b1;
    end else if (resume_go) begin
      if (psusp_r) psusp_r <= 1'b0;
      else esusp_r <= 1'b0;
    end
  end

  // sticky error bits, set wins over clear
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      err_erase_r <= 1'b0;
      err_prog_r <= 1'b0;
      err_prot_r <= 1'b0;
    end else begin
      err_erase_r <= seq_abort | (err_erase_r & ~clr_go);
      err_prog_r <= seq_abort | (err_prog_r & ~clr_go);
      err_prot_r <= prot_fail | (err_prot_r & ~clr_go);
    end
  end

  // read mode and pending second cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rmode_r <= fspc_pkg::RM_ARRAY;
      pend_r <= fspc_pkg::PD_NONE;
    end else begin
      if (rmode_we) rmode_r <= rmode_nxt;
      if (link.wr && pe_r == fspc_pkg::PE_IDLE) pend_r <= pend_nxt;
    end
  end

  // burst configuration register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) o_bcr <= fspc_pkg::BCR_RST;
    else if (bcr_we) o_bcr <= link.addr[15:0];
  end

  // per-block protection, all protected after reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_prot <= fspc_pkg::PROT_RST;
    end else if (pset) begin
      o_prot[blk] <= 1'b1;
    end else if (pclr) begin
      o_prot[blk] <= 1'b0;
    end
  end

  // read data path and activity output
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      link.rdata <= 32'h0000_0000;
      link.rvalid <= 1'b0;
      o_pe_active <= 1'b0;
    end else begin
      link.rvalid <= link.rd;
      o_pe_active <= (pe_r != fspc_pkg::PE_IDLE);
      if (link.rd) begin
        case (rmode_r)
          fspc_pkg::RM_STATUS: link.rdata <= {24'h00_0000, sr};
          fspc_pkg::RM_SIG: link.rdata <= fspc_pkg::SIG_WORD;
          fspc_pkg::RM_QUERY: link.rdata <= fspc_pkg::QUERY_WORD;
          default: link.rdata <= fspc_pkg::ERASED_WORD;
        endcase
      end
    end
  end
endmodule

//--- design/fspc_host.sv
// host end: wishbone classic slave that issues flash link cycles
// assumes software sequences commands and polls status through it
`timescale 1ns/1ns
module fspc_host (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  fspc_link_if.host link
);
  // ==========================================================
  // registers
  fspc_pkg::fspc_hst_t st_r;
  logic [31:0] addr_r;
  logic [31:0] data_r;
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic refused_r;
  logic [7:0] gap_r;
  logic susp_seen_r;
  logic nested_prog_r;
  logic wb_wr;
  logic go_wr;
  logic go_rd;
  logic [7:0] code;
  logic hold;
  logic refuse;

  // write takes effect on the edge where ack is seen
  assign wb_wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
  assign go_wr = wb_wr && i_wb_adr == fspc_pkg::H_CMD_OFF &&
    i_wb_dat[fspc_pkg::HC_WRITE_BIT] && i_wb_sel[0];
  assign go_rd = wb_wr && i_wb_adr == fspc_pkg::H_CMD_OFF &&
    i_wb_dat[fspc_pkg::HC_READ_BIT] && i_wb_sel[0];
  assign code = data_r[7:0];
  // stall a suspend until the erase has had its gap
  assign hold = (code == fspc_pkg::CMD_SUSPEND) && (gap_r != 8'h00);
  // resume after a nested program needs an array read first
  assign refuse = (code == fspc_pkg::CMD_RESUME) && nested_prog_r;

  // ==========================================================
  // wishbone ack and read data
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
      case (i_wb_adr)
        fspc_pkg::H_ADDR_OFF: o_wb_dat <= addr_r;
        fspc_pkg::H_DATA_OFF: o_wb_dat <= data_r;
        fspc_pkg::H_STAT_OFF: o_wb_dat <= {29'h0000_0000, refused_r,
          rvalid_r, st_r != fspc_pkg::HS_IDLE};
        fspc_pkg::H_RDATA_OFF: o_wb_dat <= rdata_r;
        default: o_wb_dat <= 32'h0000_0000;
      endcase
    end
  end

  // address and data registers with byte lanes
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      addr_r <= 32'h0000_0000;
      data_r <= 32'h0000_0000;
    end else if (wb_wr && st_r == fspc_pkg::HS_IDLE) begin
      for (int b = 0; b < 4; b++) begin
        if (i_wb_sel[b] && i_wb_adr == fspc_pkg::H_ADDR_OFF)
          addr_r[8*b +: 8] <= i_wb_dat[8*b +: 8];
        if (i_wb_sel[b] && i_wb_adr == fspc_pkg::H_DATA_OFF)
          data_r[8*b +: 8] <= i_wb_dat[8*b +: 8];
      end
    end
  end

  // link sequencer: one write cycle or one read per order
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r <= fspc_pkg::HS_IDLE;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      link.addr <= 24'h00_0000;
      link.wdata <= 32'h0000_0000;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      case (st_r)
        fspc_pkg::HS_IDLE: begin
          if (go_wr) st_r <= fspc_pkg::HS_WRITE;
          else if (go_rd) st_r <= fspc_pkg::HS_READ;
        end
        fspc_pkg::HS_WRITE: begin
          if (refuse) begin
            st_r <= fspc_pkg::HS_IDLE;
          end else if (!hold) begin
            // single write cycle per command
            link.wr <= 1'b1;
            link.addr <= addr_r[23:0];
            link.wdata <= data_r;
            st_r <= fspc_pkg::HS_IDLE;
          end
        end
        fspc_pkg::HS_READ: begin
          if (!link.rd && !link.rvalid) begin
            link.rd <= 1'b1;
            link.addr <= addr_r[23:0];
          end
          if (link.rvalid) st_r <= fspc_pkg::HS_IDLE;
        end
        default: st_r <= fspc_pkg::HS_IDLE;
      endcase
    end
  end

  // captured read word and flags
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (link.rvalid) rdata_r <= link.rdata;
      if (link.rvalid) rvalid_r <= 1'b1;
      else if (go_rd) rvalid_r <= 1'b0;
      if (st_r == fspc_pkg::HS_WRITE && refuse) refused_r <= 1'b1;
      else if (go_wr) refused_r <= 1'b0;
    end
  end

  // erase gap timer and nested program tracking
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      gap_r <= 8'h00;
      susp_seen_r <= 1'b0;
      nested_prog_r <= 1'b0;
    end else begin
      if (link.wr && link.wdata[7:0] == fspc_pkg::CMD_RESUME)
        gap_r <= fspc_pkg::MIN_ERASE_GAP_CYCLES;
      else if (gap_r != 8'h00)
        gap_r <= gap_r - 8'h01;
      if (link.wr) begin
        case (link.wdata[7:0])
          fspc_pkg::CMD_SUSPEND: susp_seen_r <= 1'b1;
          fspc_pkg::CMD_RESUME: susp_seen_r <= 1'b0;
          fspc_pkg::CMD_READ_ARRAY: nested_prog_r <= 1'b0;
          fspc_pkg::CMD_PROG_SETUP, fspc_pkg::CMD_BUFPROG_SETUP:
            nested_prog_r <= susp_seen_r;
          default: nested_prog_r <= nested_prog_r;
        endcase
      end
    end
  end
endmodule

//--- bench/fspc_props.sv
// link checker: read timing, status words after key commands
// assumes tb_top instantiates it beside the link interface
`timescale 1ns/1ns
module fspc_props (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic wr,
  input wire logic rd,
  input wire logic [23:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  logic [7:0] c0_r;
  logic [7:0] c1_r;
  logic setup;
  logic stat;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // last two command codes seen on the link
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
    end else if (wr) begin
      c1_r <= c0_r;
      c0_r <= wdata[7:0];
    end
  end
  // bcr, protection set and protection clear setups and status mode
  assign setup = c1_r == fspc_pkg::CMD_BCR_SETUP
    || c1_r == fspc_pkg::CMD_PSET_SETUP || c1_r == fspc_pkg::CMD_PCLR_SETUP;
  assign stat = rvalid && c0_r == fspc_pkg::CMD_READ_STATUS;
  // ==========================================================
  // properties
  property p_rv; rd |=> rvalid; endproperty
  property p_src; rvalid |-> $past(rd); endproperty
  property p_wr1; wr |=> !wr; endproperty
  property p_rd1; rd |=> !rd ##1 !rvalid; endproperty
  property p_bcr;
    rvalid && c1_r == fspc_pkg::CMD_BCR_SETUP
      && c0_r == fspc_pkg::CMD_CONFIRM |-> rdata == fspc_pkg::ERASED_WORD;
  endproperty
  property p_abort;
    rvalid && setup && c0_r != fspc_pkg::CMD_CONFIRM |-> rdata[5:4] == 2'b11;
  endproperty
  property p_resume;
    stat && c1_r == fspc_pkg::CMD_RESUME |-> !rdata[6];
  endproperty
  property p_busy; stat && !rdata[7] |-> !rdata[6] && !rdata[2]; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  a_src: assert property (p_src) else $error("stray rvalid");
  a_wr1: assert property (p_wr1) else $error("write not single");
  a_rd1: assert property (p_rd1) else $error("read not single");
  a_bcr: assert property (p_bcr) else $error("not array mode");
  a_abort: assert property (p_abort) else $error("abort bits");
  a_resume: assert property (p_resume) else $error("bit6 kept");
  a_busy: assert property (p_busy) else $error("flag while busy");
  c_susp: cover property (stat && rdata[6]);
  c_abort: cover property (rvalid && setup && rdata[5:4] == 2'b11);
  c_run: cover property (stat && !rdata[7]);
endmodule

//--- bench/tb_top.sv
// bench: wishbone host end driving the device end over the link
// assumes package, interface, both ends and checker compiled first
`timescale 1ns/1ns
module tb_top;
  logic i_clock, i_rst, cyc, we, wp_n, ack, act;
  logic [7:0] adr, prot;
  logic [15:0] bcr;
  logic [31:0] dat, wbq, q, v;
  logic [63:0] e;
  logic [63:0] eq[$];
  int n_errors, samples_checked;
  fspc_link_if lk();
  fspc_host i_fspc_host (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat),
    .i_wb_sel(4'hf), .o_wb_dat(wbq), .o_wb_ack(ack), .link(lk.host));
  fspc_dev i_fspc_dev (.i_clock(i_clock), .i_rst(i_rst), .link(lk.dev),
    .i_wp_n(wp_n), .o_bcr(bcr), .o_prot(prot), .o_pe_active(act));
  fspc_props i_fspc_props (.i_clock(i_clock), .i_rst(i_rst), .wr(lk.wr),
    .rd(lk.rd), .addr(lk.addr), .wdata(lk.wdata), .rdata(lk.rdata),
    .rvalid(lk.rvalid));
  // ==========================================================
  // compare, bus and command tasks
  task automatic chk(input string s, input logic [31:0] x, y);
    samples_checked++;
    if (y !== x) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", s, x, y);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // hold the request until ack, only the watchdog ends a hang
    do @(posedge i_clock); while (ack !== 1'b1);
    q = wbq;
    cyc <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [23:0] a);
    wb(1'b1, 8'h04, {8'h00, a});
    wb(1'b1, 8'h08, {24'h000000, c});
    wb(1'b1, 8'h00, 32'h00000001);
    // wait until the link cycle has left the host end
    do wb(1'b0, 8'h0c, 32'h0); while (q[0] !== 1'b0);
  endtask
  task automatic pr(input logic [7:0] c, input logic [2:0] b);
    cmd(c, {5'h00, b, 16'h0000});
    cmd(fspc_pkg::CMD_CONFIRM, {5'h00, b, 16'h0000});
  endtask
  task automatic rdst(input logic s, input logic [31:0] m, x);
    if (s) cmd(fspc_pkg::CMD_READ_STATUS, 24'h000000);
    eq.push_back({m, x});
    wb(1'b1, 8'h00, 32'h00000002);
    // read word is only captured once rvalid was seen
    do wb(1'b0, 8'h0c, 32'h0); while (q[1] !== 1'b1);
    wb(1'b0, 8'h10, 32'h00000000);
  endtask
  task automatic poll;
    do rdst(1'b1, 32'h00000000, 32'h00000000); while (q[7] !== 1'b1);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================================
  // monitor: oldest note against each read word
  always @(posedge i_clock) begin
    if (lk.rvalid === 1'b1 && eq.size() > 0) begin
      e = eq.pop_front();
      if (e[63:32] != 0) chk("rdata", e[31:0], lk.rdata & e[63:32]);
    end
  end
  // clock and watchdog
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  initial begin
    #2000000;
    n_errors++;
    test_done();
  end
  // main sequence
  initial begin
    i_rst = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    wp_n = 1'b1;
    v = $urandom(81);
    v = $urandom;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    chk("bcr", {16'h0, fspc_pkg::BCR_RST}, {16'h0, bcr});
    chk("prot", {24'h0, fspc_pkg::PROT_RST}, {24'h0, prot});
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    cmd(fspc_pkg::CMD_SUSPEND, 24'h0);
    rdst(1'b1, 32'hc4, 32'h80);
    cmd(fspc_pkg::CMD_BCR_SETUP, 24'h0);
    cmd(fspc_pkg::CMD_CONFIRM, v[23:0]);
    chk("bcr", {16'h0, v[15:0]}, {16'h0, bcr});
    rdst(1'b0, 32'hffffffff, fspc_pkg::ERASED_WORD);
    pr(fspc_pkg::CMD_BCR_SETUP, 3'h0);
    cmd(fspc_pkg::CMD_PSET_SETUP, 24'h0);
    cmd(8'h00, 24'h0);
    rdst(1'b0, 32'hff, 32'hb0);
    chk("bcr", 32'h0, {16'h0, bcr});
    cmd(fspc_pkg::CMD_CLR_STATUS, 24'h0);
    for (int i = 0; i < 4; i++) begin
      pr(i < 2 ? fspc_pkg::CMD_PCLR_SETUP : fspc_pkg::CMD_PSET_SETUP, 3'h2);
      chk("prot", i < 2 ? 32'hfb : 32'hff, {24'h0, prot});
    end
    wp_n <= 1'b0;
    pr(fspc_pkg::CMD_PROG_SETUP, 3'h0);
    rdst(1'b1, 32'h82, 32'h82);
    cmd(fspc_pkg::CMD_CLR_STATUS, 24'h0);
    wp_n <= 1'b1;
    pr(fspc_pkg::CMD_ERASE_SETUP, 3'h1);
    rdst(1'b1, 32'h80, 32'h00);
    chk("active", 32'h1, {31'h0, act});
    cmd(fspc_pkg::CMD_SUSPEND, 24'h0);
    poll();
    chk("suspended", 32'h40, q & 32'h44);
    cmd(fspc_pkg::CMD_SUSPEND, 24'h0);
    rdst(1'b1, 32'hc4, 32'hc0);
    cmd(fspc_pkg::CMD_READ_SIG, 24'h0);
    rdst(1'b0, 32'hffffffff, fspc_pkg::SIG_WORD);
    cmd(fspc_pkg::CMD_READ_QUERY, 24'h0);
    rdst(1'b0, 32'hffffffff, fspc_pkg::QUERY_WORD);
    cmd(fspc_pkg::CMD_BUFPROG_SETUP, 24'h030000);
    cmd(8'h00, 24'h030000);
    poll();
    chk("nested", 32'h40, q & 32'h56);
    cmd(fspc_pkg::CMD_READ_ARRAY, 24'h0);
    cmd(fspc_pkg::CMD_RESUME, 24'h0);
    rdst(1'b1, 32'h40, 32'h00);
    poll();
    chk("resumed", 32'h80, q & 32'hc4);
    test_done();
  end
endmodule
